// ---- design/pgd_pkg.sv ----
package pgd_pkg;

  // ------------------------------------------------------------
  // timebase
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_US         = 10;
  localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;
  localparam logic [8:0]  TICK_LAST       = 9'(TICK_CYCLES - 1);

  // ------------------------------------------------------------
  // delays, in microseconds and in ticks
  // ------------------------------------------------------------
  localparam int unsigned DLY_50US_US     = 50;
  localparam int unsigned DLY_50MS_US     = 50_000;
  localparam int unsigned DLY_100MS_US    = 100_000;
  localparam int unsigned DLY_200MS_US    = 200_000;
  localparam int unsigned MASK_5MS_US     = 5_000;
  localparam logic [14:0] DLY_50US_TICKS  = 15'(DLY_50US_US / TICK_US);
  localparam logic [14:0] DLY_50MS_TICKS  = 15'(DLY_50MS_US / TICK_US);
  localparam logic [14:0] DLY_100MS_TICKS = 15'(DLY_100MS_US / TICK_US);
  localparam logic [14:0] DLY_200MS_TICKS = 15'(DLY_200MS_US / TICK_US);
  localparam logic [14:0] MASK_TICKS      = 15'(MASK_5MS_US / TICK_US);

  // ------------------------------------------------------------
  // delay select codes
  // ------------------------------------------------------------
  localparam logic [1:0]  SEL_50US        = 2'h0;
  localparam logic [1:0]  SEL_50MS        = 2'h1;
  localparam logic [1:0]  SEL_100MS       = 2'h2;
  localparam logic [1:0]  SEL_200MS       = 2'h3;
  localparam logic [1:0]  SEL_RESET       = SEL_50MS;

  // ------------------------------------------------------------
  // delay timer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PGD_IDLE = 3'b001,
    PGD_RUN  = 3'b010,
    PGD_DONE = 3'b100
  } pgd_state_t;

endpackage

// ---- design/pgd_supervisor.sv ----
`timescale 1ns/1ps

// What this block does
// RQ1 - power-good low while either enabled converter below rising or falling thresholds, unless a mask timer is running
// RQ2 - release delay chosen among 50us, 50ms, 100ms, 200ms; 50ms after reset
// RQ3 - both converters use identical, interchangeable enable and in-range logic
// RQ4 - with enable high, in-range rising edge starts the delay counter
// RQ5 - output held low while counter runs, released only after full delay
// RQ6 - other converter coming in range during running delay is ignored
// RQ7 - falling in-range edge on either converter drives low and restarts delay, unless a mask timer is running
// RQ8 - output stays low forever if an enabled converter never comes in range
// RQ9 - enable rising after delay done starts 5ms mask holding output high
// RQ10 - after mask expires output follows both in-range indications
// RQ11 - power-on reset with enables forms delay timer reset, forcing low
// RQ12 - enable and in-range form set; set and reset never both active
// RQ13 - mask timers from enable rising edges, ORed with in-range, ANDed with delay timer
// RQ14 - output is open drain: driven low when asserted, else released
// RQ15 - raw supply below 2.8V forces all four regulator enables off
// RQ16 - supply-good detection uses hysteresis to avoid chattering
// RQ17 - delay select is two bits, codes 0..3, 50ms code on reset
// RQ18 - timing counted from prescaled internal clock, 10us resolution
module pgd_supervisor (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  input  wire logic [1:0] delay_sel,
  input  wire logic       delay_sel_load,
  input  wire logic       conv1_enable,
  input  wire logic       conv2_enable,
  input  wire logic       conv1_in_range,
  input  wire logic       conv2_in_range,
  input  wire logic       supply_above_hi,
  input  wire logic       supply_above_lo,
  input  wire logic [3:0] reg_enable_req,
  output logic            supply_good_out_n_o,
  output logic            supply_good_out_n_oe,
  output logic [3:0]      reg_enable,
  output logic            supply_ok
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] sync1_d;
  logic [5:0] sync2_d;
  logic [3:0] req1_q;
  logic [3:0] req2_q;
  logic [3:0] req1_d;
  logic [3:0] req2_d;

  always_comb begin
    sync1_d = {supply_above_lo, supply_above_hi, conv2_in_range, conv1_in_range, conv2_enable, conv1_enable};
    sync2_d = sync1_q;
    req1_d  = reg_enable_req;
    req2_d  = req1_q;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      req1_q  <= 4'h0;
      req2_q  <= 4'h0;
    end else if (clk_en) begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      req1_q  <= req1_d;
      req2_q  <= req2_d;
    end
  end

  logic [1:0] en_s;
  logic [1:0] rdy_s;
  logic       vhi_s;
  logic       vlo_s;
  assign en_s  = sync2_q[1:0];
  assign rdy_s = sync2_q[3:2];
  assign vhi_s = sync2_q[4];
  assign vlo_s = sync2_q[5];

  // ------------------------------------------------------------
  // prescaler and delay select
  // ------------------------------------------------------------
  logic [8:0] pre_q;
  logic [8:0] pre_d;
  logic       tick;
  logic [1:0] sel_q;
  logic [1:0] sel_d;

  function automatic logic [14:0] sel_ticks(input logic [1:0] s);
    case (s)
      pgd_pkg::SEL_50US:  sel_ticks = pgd_pkg::DLY_50US_TICKS;  // RQ2
      pgd_pkg::SEL_50MS:  sel_ticks = pgd_pkg::DLY_50MS_TICKS;
      pgd_pkg::SEL_100MS: sel_ticks = pgd_pkg::DLY_100MS_TICKS;
      pgd_pkg::SEL_200MS: sel_ticks = pgd_pkg::DLY_200MS_TICKS;
      default:            sel_ticks = pgd_pkg::DLY_50MS_TICKS;
    endcase
  endfunction

  always_comb begin
    tick  = (pre_q == pgd_pkg::TICK_LAST);  // RQ18
    pre_d = tick ? 9'h000 : pre_q + 9'h001;
    sel_d = delay_sel_load ? delay_sel : sel_q;  // RQ17
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 9'h000;
      sel_q <= pgd_pkg::SEL_RESET;  // RQ17
    end else if (clk_en) begin
      pre_q <= pre_d;
      sel_q <= sel_d;
    end
  end

  // ------------------------------------------------------------
  // per-converter edges and mask timers
  // ------------------------------------------------------------
  logic [1:0]  en_prev_q;
  logic [1:0]  rdy_prev_q;
  logic [1:0]  rdy_rise;
  logic [1:0]  rdy_fall;
  logic [1:0]  en_rise;
  logic [1:0]  mask_act;
  logic        dly_done;
  logic [14:0] mask_q [2];
  logic [14:0] mask_d [2];

  for (genvar i = 0; i < 2; i++) begin : g_conv  // RQ3
    always_comb begin
      rdy_rise[i] = en_s[i] & rdy_s[i] & ~rdy_prev_q[i];  // RQ4 RQ12
      rdy_fall[i] = rdy_prev_q[i] & ~rdy_s[i];
      en_rise[i]  = en_s[i] & ~en_prev_q[i];
      mask_act[i] = (mask_q[i] != 15'h0000);
      mask_d[i]   = mask_q[i];
      if (en_rise[i] && dly_done) begin
        mask_d[i] = pgd_pkg::MASK_TICKS;  // RQ9 RQ13
      end else if (!en_s[i]) begin
        mask_d[i] = 15'h0000;
      end else if (tick && mask_act[i]) begin
        mask_d[i] = mask_q[i] - 15'h0001;
      end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        en_prev_q[i]  <= 1'b0;
        rdy_prev_q[i] <= 1'b0;
        mask_q[i]     <= 15'h0000;
      end else if (clk_en) begin
        en_prev_q[i]  <= en_s[i];
        rdy_prev_q[i] <= rdy_s[i];
        mask_q[i]     <= mask_d[i];
      end
    end
  end

  // ------------------------------------------------------------
  // delay timer
  // ------------------------------------------------------------
  pgd_pkg::pgd_state_t st_q;
  pgd_pkg::pgd_state_t st_d;
  logic [14:0]         cnt_q;
  logic [14:0]         cnt_d;
  logic                tmr_reset;
  logic                tmr_set;
  logic                tmr_fall;

  always_comb begin
    tmr_reset = ~(en_s[0] | en_s[1]);  // RQ11
    tmr_set   = ~tmr_reset & ((en_s[0] & rdy_s[0]) | (en_s[1] & rdy_s[1]));  // RQ12
    tmr_fall  = |(rdy_fall & en_s);
    st_d      = st_q;
    cnt_d     = cnt_q;
    case (st_q)
      pgd_pkg::PGD_IDLE: begin
        if (tmr_set && (|rdy_rise)) begin
          st_d  = pgd_pkg::PGD_RUN;  // RQ4
          cnt_d = sel_ticks(sel_q);
        end
      end
      pgd_pkg::PGD_RUN: begin
        if (tmr_fall) begin
          cnt_d = sel_ticks(sel_q);  // RQ7
        end else if (tick) begin
          if (cnt_q == 15'h0000) begin
            st_d  = pgd_pkg::PGD_DONE;  // RQ5
            cnt_d = 15'h0000;
          end else begin
            cnt_d = cnt_q - 15'h0001;  // RQ6
          end
        end
      end
      pgd_pkg::PGD_DONE: begin
        if (tmr_fall && !(|mask_act)) begin
          st_d  = pgd_pkg::PGD_RUN;  // RQ7
          cnt_d = sel_ticks(sel_q);
        end
      end
      default: begin
        st_d  = pgd_pkg::PGD_IDLE;
        cnt_d = 15'h0000;
      end
    endcase
    if (tmr_reset) begin
      st_d  = pgd_pkg::PGD_IDLE;  // RQ11
      cnt_d = 15'h0000;
    end
  end

  assign dly_done = (st_q == pgd_pkg::PGD_DONE);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q  <= pgd_pkg::PGD_IDLE;
      cnt_q <= 15'h0000;
    end else if (clk_en) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ------------------------------------------------------------
  // output combine, lockout
  // ------------------------------------------------------------
  logic       good;
  logic       pg_oe_q;
  logic       pg_oe_d;
  logic       pg_o_q;
  logic       vok_q;
  logic       vok_d;
  logic [3:0] ren_q;
  logic [3:0] ren_d;

  always_comb begin
    // enabled converters must be in range, unless masked
    // the enable edge itself is covered so the pin never blips before the mask loads
    good = dly_done & ((|mask_act) | (|en_rise) | (&(rdy_s | ~en_s)));  // RQ1 RQ8 RQ9 RQ10 RQ13
    pg_oe_d = ~good;  // RQ14
    vok_d = vok_q;
    if (vhi_s) begin
      vok_d = 1'b1;  // RQ16
    end else if (!vlo_s) begin
      vok_d = 1'b0;
    end
    ren_d = vok_q ? req2_q : 4'h0;  // RQ15
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pg_oe_q <= 1'b1;
      pg_o_q  <= 1'b0;
      vok_q   <= 1'b0;
      ren_q   <= 4'h0;
    end else if (clk_en) begin
      pg_oe_q <= pg_oe_d;
      pg_o_q  <= 1'b0;  // RQ14
      vok_q   <= vok_d;
      ren_q   <= ren_d;
    end
  end

  assign supply_good_out_n_oe = pg_oe_q;  // RQ14
  assign supply_good_out_n_o  = pg_o_q;
  assign reg_enable           = ren_q;
  assign supply_ok            = vok_q;

endmodule

// ---- dv/pgd_host_model.sv ----
`timescale 1ns/1ps
module pgd_host_model (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output wire logic pin
);
  // pull-up when released
  assign pin = pin_oe ? pin_o : 1'b1;
endmodule

// ---- dv/pgd_properties.sv ----
`timescale 1ns/1ps
module pgd_properties (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       conv1_enable,
  input wire logic       conv2_enable,
  input wire logic       conv1_in_range,
  input wire logic       conv2_in_range,
  input wire logic       supply_above_hi,
  input wire logic       supply_above_lo,
  input wire logic [3:0] reg_enable_req,
  input wire logic       supply_good_out_n_o,
  input wire logic       supply_good_out_n_oe,
  input wire logic [3:0] reg_enable,
  input wire logic       supply_ok
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // low time counter
  // ----------------------------------------
  logic [15:0] low_cnt_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) low_cnt_q <= 16'h0000;
    else if (!supply_good_out_n_oe) low_cnt_q <= 16'h0000;
    else if (low_cnt_q != 16'hffff) low_cnt_q <= low_cnt_q + 16'h0001;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_od_data_low: assert property (supply_good_out_n_o == 1'b0) else $error("pin data not low");
  a_enables_off_low: assert property ((!conv1_enable && !conv2_enable) [*4] |-> supply_good_out_n_oe)
    else $error("pin released with enables off");
  a_lockout_forces_off: assert property ((!supply_above_lo) [*5] |-> (reg_enable == 4'h0) && !supply_ok)
    else $error("enables not forced off");
  a_enables_pass: assert property ((supply_above_hi && supply_above_lo && $stable(reg_enable_req)) [*6]
    |-> reg_enable == reg_enable_req) else $error("enables not passed");
  a_hyst_keeps_ok: assert property ((supply_ok && supply_above_lo) [*4] |=> supply_ok)
    else $error("supply ok dropped above low trip");
  a_hyst_keeps_off: assert property ((!supply_ok && !supply_above_hi) [*4] |=> !supply_ok)
    else $error("supply ok set below high trip");
  a_release_after_delay: assert property ($fell(supply_good_out_n_oe) |-> $past(low_cnt_q) >= 16'd2499)
    else $error("pin released early");
  a_fall_restarts: assert property (conv1_enable && conv2_enable && ($fell(conv1_in_range) ||
    $fell(conv2_in_range)) |-> ##[1:6] supply_good_out_n_oe) else $error("fall did not pull pin low");
endmodule

bind pgd_supervisor pgd_properties u_props (.core_clk, .resetn, .conv1_enable, .conv2_enable, .conv1_in_range,
  .conv2_in_range, .supply_above_hi, .supply_above_lo, .reg_enable_req, .supply_good_out_n_o,
  .supply_good_out_n_oe, .reg_enable, .supply_ok);

// ---- dv/pgd_supervisor_tb.sv ----
`timescale 1ns/1ps
module pgd_supervisor_tb;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [1:0]  sel = 2'h0;
  logic        ld = 1'b0, en1 = 1'b0, en2 = 1'b0, rd1 = 1'b0, rd2 = 1'b0, hi = 1'b0, lo = 1'b0;
  logic [3:0]  req = 4'h0;
  logic        o, oe, ok, pin;
  logic [3:0]  ren;
  logic [31:0] rs = 32'h0000_8210;
  logic [5:0]  exp_q[$];
  logic [5:0]  msk_q[$];
  logic        chk_req = 1'b0;
  int          failures = 0, check_count = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  pgd_supervisor dut (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1), .delay_sel(sel), .delay_sel_load(ld),
    .conv1_enable(en1), .conv2_enable(en2), .conv1_in_range(rd1), .conv2_in_range(rd2), .supply_above_hi(hi),
    .supply_above_lo(lo), .reg_enable_req(req), .supply_good_out_n_o(o), .supply_good_out_n_oe(oe),
    .reg_enable(ren), .supply_ok(ok));
  pgd_host_model host (.pin_o(o), .pin_oe(oe), .pin(pin));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic expect_out(input logic [5:0] v, input logic [5:0] m);
    exp_q.push_back(v);
    msk_q.push_back(m);
    chk_req = ~chk_req;
  endtask
  task automatic complete_run;
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // monitor
  // ----------------------------------------
  always @(chk_req) begin
    logic [5:0] v, m;
    v = exp_q.pop_front();
    m = msk_q.pop_front();
    check_count++;
    if (({pin, ok, ren} & m) !== v) begin
      failures++;
      $display("[ERR] %0t outputs %b expected %b", $time, {pin, ok, ren} & m, v);
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      complete_run();
    end
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    step(5);
    resetn = 1'b1;
    step(1);
    expect_out(6'h00, 6'h3f);
    rs = xs(rs);
    req = rs[3:0];
    hi = 1'b1;
    lo = 1'b1;
    step(6);
    expect_out({2'b01, req}, 6'h1f);
    hi = 1'b0;
    step(6);
    expect_out(6'h10, 6'h10);
    lo = 1'b0;
    step(6);
    expect_out(6'h00, 6'h1f);
    hi = 1'b1;
    lo = 1'b1;
    req = rs[7:4];
    step(6);
    expect_out({2'b01, req}, 6'h1f);
    en1 = 1'b1;
    en2 = 1'b1;
    step(2);
    rd1 = 1'b1;
    rd2 = 1'b1;
    step(5000);
    expect_out(6'h00, 6'h20);
    en1 = 1'b0;
    en2 = 1'b0;
    rd1 = 1'b0;
    rd2 = 1'b0;
    for (int c = 3; c >= 0; c--) begin
      sel = 2'(c);
      ld = 1'b1;
      step(1);
    end
    ld = 1'b0;
    en1 = 1'b1;
    en2 = 1'b1;
    step(4);
    rd1 = 1'b1;
    step(1000);
    rd2 = 1'b1;
    step(900);
    expect_out(6'h00, 6'h20);
    step(1300);
    expect_out(6'h20, 6'h20);
    rd2 = 1'b0;
    step(8);
    expect_out(6'h00, 6'h20);
    rd2 = 1'b1;
    step(1900);
    expect_out(6'h00, 6'h20);
    step(1300);
    expect_out(6'h20, 6'h20);
    rd2 = 1'b0;
    step(4000);
    expect_out(6'h00, 6'h20);
    en2 = 1'b0;
    step(8);
    expect_out(6'h20, 6'h20);
    en2 = 1'b1;
    step(3000);
    expect_out(6'h20, 6'h20);
    step(5);
    complete_run();
  end
endmodule
